// ==== verilog/lin_uart_defs.vh ====
// register map, field positions and reset values of the lin uart status block
// Operation
// - holding-empty flag high when data register can take a byte; write clears it
// - idle flag is 1 once shifter is empty and character fully sent
// - in normal mode the clear-to-send status bit reads the present input level
// - loopback replaces external clear-to-send with internal receive-byte-ready signal
// - clear-to-send gates transmission only while flow control enable is 1
// - byte-ready flag sets when a byte is held; data register read clears it
// - lin mode sets bus-mismatch flag when read-back bus bit differs from sent
// - reading lin status zero or receive data register clears bus-mismatch flag
`ifndef LIN_UART_DEFS_VH
`define LIN_UART_DEFS_VH

// register indices; byte address is four times the index
`define IDX_DATA     12'hf40
`define IDX_STAT0    12'hf41
`define IDX_CTRL     12'hf42
`define IDX_DIV      12'hf43
`define IDX_ISTAT    12'hf44
`define IDX_IMASK    12'hf45

// status zero fields
`define ST_RDY       7
`define ST_MISM      6
`define ST_OVR       5
`define ST_FRM       4
`define ST_BRK       3
`define ST_THE       2
`define ST_IDLE      1
`define ST_CTS       0
`define STAT0_RESET  8'h06

// control fields
`define CT_LIN       0
`define CT_LOOP      1
`define CT_FLOW      2
`define CTRL_RESET   8'h00

// interrupt status and mask fields
`define IB_RX        0
`define IB_THE       1
`define IB_TXDONE    2
`define IB_ERR       3
`define INT_W        4

// divisor after reset
`define DIV_RESET    16'h01b2

// axi responses
`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10

`endif

// ==== verilog/lin_uart_status_and_baud.v ====
// lin-capable uart with status flags, flow control and baud divisor, axi4-lite slave
`include "lin_uart_defs.vh"
`default_nettype none

module lin_uart_status_and_baud (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [15:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [15:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        rxd,
  output reg         txd,
  input  wire        cts_n,
  output reg         irq
);

  // register selector codes
  localparam [2:0] SEL_NONE  = 3'd0;
  localparam [2:0] SEL_DATA  = 3'd1;
  localparam [2:0] SEL_STAT0 = 3'd2;
  localparam [2:0] SEL_CTRL  = 3'd3;
  localparam [2:0] SEL_DIV   = 3'd4;
  localparam [2:0] SEL_ISTAT = 3'd5;
  localparam [2:0] SEL_IMASK = 3'd6;

  // serial frame states, shared by both directions
  localparam [1:0] S_IDLE  = 2'd0;
  localparam [1:0] S_START = 2'd1;
  localparam [1:0] S_DATA  = 2'd2;
  localparam [1:0] S_STOP  = 2'd3;

  // address decode; upper address bits must be zero
  function [2:0] reg_sel;
    input [15:0] a;
    begin
      if (a[15:14] != 2'b00)
        reg_sel = SEL_NONE;
      else
        case (a[13:2])
          `IDX_DATA:  reg_sel = SEL_DATA;
          `IDX_STAT0: reg_sel = SEL_STAT0;
          `IDX_CTRL:  reg_sel = SEL_CTRL;
          `IDX_DIV:   reg_sel = SEL_DIV;
          `IDX_ISTAT: reg_sel = SEL_ISTAT;
          `IDX_IMASK: reg_sel = SEL_IMASK;
          default:    reg_sel = SEL_NONE;
        endcase
    end
  endfunction

  reg  [15:0]        aw_addr;
  reg  [31:0]        w_data;
  reg  [3:0]         w_strb;
  reg  [7:0]         ctrl;
  reg  [15:0]        divisor;
  reg  [`INT_W-1:0]  imask;
  reg  [`INT_W-1:0]  istat;
  reg  [7:0]         tx_hold;
  reg                tx_holding_empty;
  reg  [1:0]         tx_state;
  reg  [15:0]        tx_cnt;
  reg  [2:0]         tx_bit;
  reg  [7:0]         tx_shift;
  reg  [1:0]         rx_state;
  reg  [15:0]        rx_cnt;
  reg  [2:0]         rx_bit;
  reg  [7:0]         rx_shift;
  reg  [7:0]         rx_data;
  reg                rx_prev;
  reg                rx_byte_ready;
  reg                overrun;
  reg                framing_error;
  reg                break_detected;
  reg                bus_mismatch_error;
  reg                rx_done;
  reg                tx_load;
  reg                tx_done;

  wire        wr_do;
  wire [2:0]  wr_sel;
  wire        rd_do;
  wire [2:0]  rd_sel;
  wire        rd_data_clr;
  wire        rd_stat_clr;
  wire        lin_mode;
  wire        loopback_enable;
  wire        flow_control_enable;
  wire [15:0] div_eff;
  wire [15:0] div_half;
  wire        cts_level;
  wire        tx_clear;
  wire        rx_line;
  wire        tx_idle_flag;
  wire        autobaud_flag;
  wire        tx_bit_end;
  wire        rx_bit_end;
  wire        rx_half;
  wire [7:0]  stat0;

  // write fires once both address and data are held and no response waits
  assign wr_do       = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wr_sel      = reg_sel(aw_addr);
  assign rd_do       = s_axi_arvalid & s_axi_arready;
  assign rd_sel      = reg_sel(s_axi_araddr);
  assign rd_data_clr = rd_do & (rd_sel == SEL_DATA);
  assign rd_stat_clr = rd_do & (rd_sel == SEL_STAT0);

  assign lin_mode            = ctrl[`CT_LIN];
  assign loopback_enable     = ctrl[`CT_LOOP];
  assign flow_control_enable = ctrl[`CT_FLOW];

  // a zero divisor would stall the counters, so it runs as one
  assign div_eff  = (divisor == 16'h0000) ? 16'h0001 : divisor;
  assign div_half = {1'b0, div_eff[15:1]};

  // loopback: receiver holding a byte means not clear, external pin ignored
  assign cts_level = loopback_enable ? rx_byte_ready : cts_n;
  assign tx_clear  = ~flow_control_enable | ~cts_level;
  assign rx_line   = loopback_enable ? txd : rxd;

  assign tx_idle_flag = (tx_state == S_IDLE);
  // automatic baud detection is not built; flag reads zero
  assign autobaud_flag = 1'b0;

  assign tx_bit_end = (tx_cnt == div_eff - 16'h0001);
  assign rx_bit_end = (rx_cnt == div_eff - 16'h0001);
  assign rx_half    = (rx_cnt == div_half);

  // bit zero shows clear-to-send in normal mode, autobaud in lin mode
  assign stat0 = {rx_byte_ready, bus_mismatch_error, overrun, framing_error,
                  break_detected, tx_holding_empty, tx_idle_flag,
                  lin_mode ? autobaud_flag : cts_level};

  // axi write channel handshakes; address and data taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_addr       <= 16'h0000;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_do)
      begin
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // axi read channel; value captured before the read side effects land
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else if (rd_do)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `RESP_OKAY;
      case (rd_sel)
        SEL_DATA:  s_axi_rdata <= {24'h000000, rx_data};
        SEL_STAT0: s_axi_rdata <= {24'h000000, stat0};
        SEL_CTRL:  s_axi_rdata <= {24'h000000, ctrl};
        SEL_DIV:   s_axi_rdata <= {16'h0000, divisor};
        SEL_ISTAT: s_axi_rdata <= {28'h0000000, istat};
        SEL_IMASK: s_axi_rdata <= {28'h0000000, imask};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // software-written configuration
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl    <= `CTRL_RESET;
      divisor <= `DIV_RESET;
      imask   <= {`INT_W{1'b0}};
    end
    else if (wr_do)
    begin
      if (wr_sel == SEL_CTRL && w_strb[0])
        ctrl <= {5'b00000, w_data[2:0]};
      if (wr_sel == SEL_DIV && w_strb[0])
        divisor[7:0] <= w_data[7:0];
      if (wr_sel == SEL_DIV && w_strb[1])
        divisor[15:8] <= w_data[15:8];
      if (wr_sel == SEL_IMASK && w_strb[0])
        imask <= w_data[`INT_W-1:0];
    end
  end

  // transmitter: holding register feeds the shifter, lsb first, one stop bit
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_hold          <= 8'h00;
      tx_holding_empty <= 1'b1;
      tx_state         <= S_IDLE;
      tx_cnt           <= 16'h0000;
      tx_bit           <= 3'd0;
      tx_shift         <= 8'h00;
      txd              <= 1'b1;
      tx_load          <= 1'b0;
      tx_done          <= 1'b0;
    end
    else
    begin
      tx_load <= 1'b0;
      tx_done <= 1'b0;
      case (tx_state)
        S_IDLE:
        begin
          // a byte waits in holding until the peer is clear
          if (!tx_holding_empty && tx_clear)
          begin
            tx_shift         <= tx_hold;
            tx_holding_empty <= 1'b1;
            tx_load          <= 1'b1;
            txd              <= 1'b0;
            tx_cnt           <= 16'h0000;
            tx_state         <= S_START;
          end
        end
        S_START:
        begin
          tx_cnt <= tx_cnt + 16'h0001;
          if (tx_bit_end)
          begin
            tx_cnt   <= 16'h0000;
            tx_bit   <= 3'd0;
            txd      <= tx_shift[0];
            tx_state <= S_DATA;
          end
        end
        S_DATA:
        begin
          tx_cnt <= tx_cnt + 16'h0001;
          if (tx_bit_end)
          begin
            tx_cnt   <= 16'h0000;
            tx_bit   <= tx_bit + 3'd1;
            tx_shift <= {1'b0, tx_shift[7:1]};
            txd      <= (tx_bit == 3'd7) ? 1'b1 : tx_shift[1];
            if (tx_bit == 3'd7)
              tx_state <= S_STOP;
          end
        end
        S_STOP:
        begin
          tx_cnt <= tx_cnt + 16'h0001;
          // idle flag rises only after the full stop bit
          if (tx_bit_end)
          begin
            tx_cnt   <= 16'h0000;
            tx_done  <= 1'b1;
            tx_state <= S_IDLE;
          end
        end
        default:
        begin
          txd      <= 1'b1;
          tx_state <= S_IDLE;
        end
      endcase
      // a late write overrides the load of the same cycle, keeping the flag low
      if (wr_do && wr_sel == SEL_DATA && w_strb[0])
      begin
        tx_hold          <= w_data[7:0];
        tx_holding_empty <= 1'b0;
      end
    end
  end

  // receiver: falling edge, mid-bit check of start, then full-bit samples
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_state       <= S_IDLE;
      rx_cnt         <= 16'h0000;
      rx_bit         <= 3'd0;
      rx_shift       <= 8'h00;
      rx_data        <= 8'h00;
      rx_prev        <= 1'b1;
      rx_byte_ready  <= 1'b0;
      overrun        <= 1'b0;
      framing_error  <= 1'b0;
      break_detected <= 1'b0;
      rx_done        <= 1'b0;
    end
    else
    begin
      rx_prev <= rx_line;
      rx_done <= 1'b0;
      // clears first so that a completing frame in the same cycle wins
      if (rd_data_clr)
      begin
        rx_byte_ready <= 1'b0;
        overrun       <= 1'b0;
        framing_error <= 1'b0;
      end
      if (rd_stat_clr)
        break_detected <= 1'b0;
      case (rx_state)
        S_IDLE:
        begin
          rx_cnt <= 16'h0000;
          if (rx_prev && !rx_line)
            rx_state <= S_START;
        end
        S_START:
        begin
          rx_cnt <= rx_cnt + 16'h0001;
          if (rx_half)
          begin
            rx_cnt   <= 16'h0000;
            rx_bit   <= 3'd0;
            rx_state <= rx_line ? S_IDLE : S_DATA;
          end
        end
        S_DATA:
        begin
          rx_cnt <= rx_cnt + 16'h0001;
          if (rx_bit_end)
          begin
            rx_cnt   <= 16'h0000;
            rx_bit   <= rx_bit + 3'd1;
            rx_shift <= {rx_line, rx_shift[7:1]};
            if (rx_bit == 3'd7)
              rx_state <= S_STOP;
          end
        end
        S_STOP:
        begin
          rx_cnt <= rx_cnt + 16'h0001;
          if (rx_bit_end)
          begin
            rx_cnt        <= 16'h0000;
            rx_data       <= rx_shift;
            rx_done       <= 1'b1;
            rx_byte_ready <= 1'b1;
            if (rx_byte_ready && !rd_data_clr)
              overrun <= 1'b1;
            if (!rx_line)
              framing_error <= 1'b1;
            if (!rx_line && rx_shift == 8'h00)
              break_detected <= 1'b1;
            rx_state <= S_IDLE;
          end
        end
        default:
          rx_state <= S_IDLE;
      endcase
    end
  end

  // lin read-back compare at mid-bit while a frame is on the wire
  always @(posedge aclk)
  begin
    if (!aresetn)
      bus_mismatch_error <= 1'b0;
    else if (lin_mode && tx_state != S_IDLE && tx_cnt == div_half
             && rx_line != txd)
      bus_mismatch_error <= 1'b1;
    else if (rd_stat_clr || rd_data_clr)
      bus_mismatch_error <= 1'b0;
  end

  // sticky interrupt status, write one to clear, new events win
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      istat <= {`INT_W{1'b0}};
      irq   <= 1'b0;
    end
    else
    begin
      istat <= (istat & ~((wr_do && wr_sel == SEL_ISTAT && w_strb[0])
                          ? w_data[`INT_W-1:0] : {`INT_W{1'b0}}))
               | {(overrun | framing_error | bus_mismatch_error) & ~istat[`IB_ERR]
                    ? 1'b1 : 1'b0,
                  tx_done, tx_load, rx_done};
      // one cycle behind the status so the pin stays a clean flop output
      irq <= |(istat & imask);
    end
  end

endmodule // lin_uart_status_and_baud

`default_nettype wire

// ==== test/lin_uart_properties.sv ====
// assertion checker for the lin uart register bus and serial transmit timing
`include "lin_uart_defs.vh"
`default_nettype none

module lin_uart_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [15:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        txd,
  input wire logic        cts_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reg  [15:0] wa;
  reg  [15:0] ra;
  reg  [15:0] dv;
  reg  [7:0]  ct;
  reg  [19:0] c;
  reg         act;
  reg         tq;
  wire        wr   = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire [19:0] flen = 20'd10 * dv;

  // mapped window; upper address bits must be clear
  function automatic logic mp(input logic [15:0] a);
    mp = a[15:14] == 2'b00 && a[13:2] >= `IDX_DATA && a[13:2] <= `IDX_IMASK;
  endfunction

  // shadows of divisor and control, plus a frame cycle counter
  always @(posedge aclk)
  begin
    tq <= txd;
    if (!aresetn)
    begin
      dv  <= `DIV_RESET;
      ct  <= `CTRL_RESET;
      act <= 1'b0;
      c   <= 20'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
      if (wr && s_axi_awaddr[13:2] == `IDX_DIV) dv <= s_axi_wdata[15:0];
      if (wr && s_axi_awaddr[13:2] == `IDX_CTRL) ct <= s_axi_wdata[7:0];
      // back-to-back frames: a new start may fall right at the old end
      if (tq && !txd && (!act || c >= flen))
      begin
        act <= 1'b1;
        c   <= 20'h1;
      end
      else if (act)
      begin
        c <= c + 20'h1;
        if (c >= flen) act <= 1'b0;
      end
    end
  end

  AST_WR_RESP: assert property (wr |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  AST_WR_CODE: assert property ($rose(s_axi_bvalid) |->
    s_axi_bresp == (mp(wa) ? `RESP_OKAY : `RESP_SLVERR)) else $error("bad write response");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  AST_RD_CODE: assert property ($rose(s_axi_rvalid) |->
    s_axi_rresp == (mp(ra) ? `RESP_OKAY : `RESP_SLVERR) && (mp(ra) || s_axi_rdata == 32'h0))
    else $error("bad read response");
  AST_AR_HELD: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  AST_BIT_EDGE: assert property (act && txd != tq |-> c % dv == 20'h0)
    else $error("serial edge off the bit grid");
  AST_STOP_HIGH: assert property (act && c == 20'd9 * dv |-> txd)
    else $error("stop bit not high");
  AST_CTS_GATE: assert property (ct[`CT_FLOW] && !ct[`CT_LOOP] && cts_n && $past(cts_n)
    && $past(cts_n, 2) && txd && !act |=> txd) else $error("sent while cts high");
  AST_CTS_READ: assert property ($rose(s_axi_rvalid) && ra[13:2] == `IDX_STAT0
    && ct[1:0] == 2'b00 && cts_n == $past(cts_n) && cts_n == $past(cts_n, 2)
    |-> s_axi_rdata[`ST_CTS] == cts_n) else $error("cts bit wrong");
  AST_IDLE_LOW: assert property ($rose(s_axi_rvalid) && ra[13:2] == `IDX_STAT0 && act
    && c > 20'h2 && c < 20'd9 * dv |-> !s_axi_rdata[`ST_IDLE]) else $error("idle while shifting");
endmodule // lin_uart_properties

bind lin_uart_status_and_baud lin_uart_properties u_props (.*);

`default_nettype wire

// ==== test/lin_bus_peer.sv ====
// bus echo model: the line reads back what the node drives
`default_nettype none

module lin_bus_peer (
  input  wire logic aclk,
  input  wire logic txd,
  input  wire logic garble,
  output var  logic rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rxd = 1'b1;
  // one cycle of bus delay; garble is another node holding the bus dominant
  always @(posedge aclk)
    rxd <= txd & ~garble;
endmodule // lin_bus_peer

`default_nettype wire

// ==== test/test_lin_uart_status_and_baud.sv ====
// self-checking bench for the lin uart status flags, flow control and divisor
`include "lin_uart_defs.vh"
`default_nettype none

module test_lin_uart_status_and_baud;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [15:0] A_DAT = {2'b00, `IDX_DATA, 2'b00};
  localparam [15:0] A_ST  = {2'b00, `IDX_STAT0, 2'b00};
  localparam [15:0] A_CT  = {2'b00, `IDX_CTRL, 2'b00};
  localparam [15:0] A_DV  = {2'b00, `IDX_DIV, 2'b00};
  localparam [15:0] A_IS  = {2'b00, `IDX_ISTAT, 2'b00};
  localparam [15:0] A_IM  = {2'b00, `IDX_IMASK, 2'b00};
  localparam [15:0] DIVN  = 16'h0008; // 50 MHz over 6.25 Mbit/s, exact
  logic        aresetn = 1'b0, cts_n = 1'b1, garble = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        aclk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, rxd, txd, irq;
  int          fails = 0, cmp_count = 0;

  lin_uart_status_and_baud u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd, .txd, .cts_n, .irq);
  lin_bus_peer u_peer (.aclk, .txd, .garble, .rxd);

  // 50 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [15:0] a, input logic [31:0] v, input logic [3:0] s);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!got)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        got = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [15:0] a);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!got)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        got = 1'b1;
      end
    end
  endtask

  task automatic rc(input logic [15:0] a, input logic [31:0] m, e, input string nm);
    rd(a);
    chk(nm, e, d & m);
  endtask

  // polling is safe only outside the mismatch test: a status read clears it
  task automatic poll(input int b);
    d = 32'h0;
    while (d[b] !== 1'b1) rd(A_ST);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // cut a hang short, well past the expected run length
  initial
  begin
    #400000;
    fails++;
    $display("[FAIL] watchdog expected done seen hang");
    wrap_up;
  end

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rc(A_ST, 32'hff, 32'h07, "status reset");
    rc(A_DV, 32'hffff, {16'h0, `DIV_RESET}, "divisor reset");
    rd(16'h3d18);
    chk("unmapped read", {30'h0, `RESP_SLVERR}, {d[29:0], r});
    wr(16'h3d18, 32'h1, 4'hf);
    chk("unmapped write", {30'h0, `RESP_SLVERR}, {30'h0, r});
    wr(A_ST, 32'h0, 4'hf);
    rc(A_ST, 32'hff, 32'h07, "read-only status");
    wr(A_DV, {16'h0, DIVN}, 4'h3);
    rc(A_DV, 32'hffff, {16'h0, DIVN}, "divisor");
    // flow control off with cts high: both bytes still go out
    wr(A_DAT, 32'ha5, 4'h1);
    wr(A_DAT, 32'h3c, 4'h1);
    rc(A_ST, 32'h06, 32'h00, "holding full");
    poll(`ST_RDY);
    rc(A_DAT, 32'hff, 32'ha5, "first byte");
    rc(A_ST, 32'h80, 32'h00, "ready cleared");
    poll(`ST_RDY);
    rc(A_DAT, 32'hff, 32'h3c, "second byte");
    poll(`ST_IDLE);
    rc(A_ST, 32'hff, 32'h07, "all quiet");
    chk("irq masked", 32'h0, {31'h0, irq});
    rc(A_IS, 32'hf, 32'h7, "event bits");
    wr(A_IM, 32'hf, 4'h1);
    repeat (2) @(posedge aclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(A_IS, 32'hf, 4'h1);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // flow control on: a high cts holds the byte back
    wr(A_CT, 32'h4, 4'h1);
    wr(A_DAT, 32'h5a, 4'h1);
    repeat (40) @(posedge aclk);
    rc(A_ST, 32'h07, 32'h03, "held by cts");
    cts_n <= 1'b0;
    poll(`ST_RDY);
    rc(A_DAT, 32'hff, 32'h5a, "released byte");
    rc(A_ST, 32'h01, 32'h00, "cts low level");
    cts_n <= 1'b1;
    // loopback: receive ready stands in for cts
    wr(A_CT, 32'h6, 4'h1);
    wr(A_DAT, 32'h11, 4'h1);
    poll(`ST_RDY);
    wr(A_DAT, 32'h22, 4'h1);
    repeat (40) @(posedge aclk);
    rc(A_ST, 32'h86, 32'h82, "held by ready");
    rc(A_DAT, 32'hff, 32'h11, "loop byte one");
    poll(`ST_RDY);
    rc(A_DAT, 32'hff, 32'h22, "loop byte two");
    repeat (40) @(posedge aclk);
    // lin mode: clean frame, then a fought bus cleared by each kind of read
    wr(A_CT, 32'h1, 4'h1);
    for (int i = 0; i < 3; i++)
    begin
      wr(A_DAT, 32'h55, 4'h1);
      garble <= (i != 0);
      repeat (100) @(posedge aclk);
      garble <= 1'b0;
      if (i == 2)
        rd(A_DAT);
      else
        rc(A_ST, 32'h40, {25'h0, i[0], 6'h0}, "mismatch flag");
      rc(A_ST, 32'h40, 32'h00, "mismatch cleared");
    end
    // fought frames leave the sticky error event, which the mask lets through
    rc(A_IS, 32'h8, 32'h8, "error event");
    chk("irq on error", 32'h1, {31'h0, irq});
    wrap_up;
  end
endmodule // test_lin_uart_status_and_baud

`default_nettype wire
